// ---- core/rcst_defines.svh ----
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit axi4-lite slave port and a 50 mhz aclk
//
// Summary of operation
// RL1: cause register sits at index 8Eh and reports the last reset type.
// RL2: bit 0 is active-low brown-out flag, cleared by a brown-out reset.
// RL3: with brown-out mode 00 the brown-out flag is meaningless.
// RL4: bit 1 is active-low power-on flag, cleared only by power-on reset.
// RL5: software sets both flags after power-on, then a zero shows the cause.
// RL6: crystal modes wait timer plus 1024 oscillator periods; wake waits 1024.
// RL7: other oscillator modes wait only the enabled power-up timer; no wake wait.
// RL8: power-on and brown-out reset set timeout and powerdown flags to 1.
// RL9: watchdog, watchdog wake and master-clear update timeout and powerdown flags.
// RL10: power reset reads --01 --qq, other resets --0u --uu.
// RL11: bit 5 ultra-low-power wake enable, bit 4 soft brown-out enable, rest zero.
// RL12: core status resets to 0001 1xxx on power, else 000q quuu.
// RL13: power-up timer holds reset 64 ms; brown-out during it restarts it.
// RL14: power-up timer runs first, oscillator start-up timer after it.
// RL15: active-low timer enable bit enables the power-up timer when 0.
// RL16: software flag writes act next edge; hardware events win same cycle.
`ifndef RCST_DEFINES_SVH
`define RCST_DEFINES_SVH

// register indices; byte address is four times the index
`define RCST_IDX_CAUSE 8'h8E
`define RCST_IDX_CORE 8'h8F
`define RCST_IDX_IRQ_STAT 8'h90
`define RCST_IDX_IRQ_EN 8'h91
`define RCST_IDX_IRQ_CLR 8'h92
`define RCST_IDX_CONFIG 8'h93

// cause register fields
`define RCST_BIT_BROWN_N 0
`define RCST_BIT_POR_N 1
`define RCST_BIT_SOFT_BROWN 4
`define RCST_BIT_ULP_WAKE 5
`define RCST_CAUSE_MASK 8'h33

// core status fields
`define RCST_BIT_PDOWN_N 3
`define RCST_BIT_TIMEOUT_N 4
`define RCST_CORE_SW_MASK 8'hE7

// config register fields
`define RCST_BIT_PUP_EN_N 0
`define RCST_BIT_BMODE 1
`define RCST_BIT_OSC 3
`define RCST_BIT_SECOSC 5
`define RCST_CONFIG_MASK 8'h3F
`define RCST_CONFIG_RESET 8'h06

// irq status bits
`define RCST_IRQ_WIDTH 6
`define RCST_IRQ_POR 0
`define RCST_IRQ_BROWN 1
`define RCST_IRQ_WDOG 2
`define RCST_IRQ_WAKE 3
`define RCST_IRQ_MRESET 4
`define RCST_IRQ_DONE 5

// reset values after power-on
`define RCST_CAUSE_POR 8'h11
`define RCST_CORE_POR 8'h18

// timing
`define RCST_CLK_KHZ 50000
`define RCST_PUP_MS 64
`define RCST_PUP_CYCLES (`RCST_PUP_MS * `RCST_CLK_KHZ)
`define RCST_OSC_WAIT_PERIODS 1024

`endif

// ---- core/rcst_pkg.sv ----
// types shared by the reset cause and start-up timeout block
// assumes the defines header for all numeric constants
package rcst_pkg;

    typedef enum logic [3:0] {
        ST_SUPPLY = 4'b0001,
        ST_PUP = 4'b0010,
        ST_OSC = 4'b0100,
        ST_RUN = 4'b1000
    } rcst_state_t;

    typedef enum logic [1:0] {
        OSC_CRYSTAL = 2'b00,
        OSC_HIGH_SPEED = 2'b01,
        OSC_LOW_POWER = 2'b10,
        OSC_NON_CRYSTAL = 2'b11
    } rcst_osc_t;

endpackage

// ---- core/rcst_top.sv ----
// reset cause flags, start-up timeout sequencer and axi4-lite register slave
// assumes reset event pins arrive asynchronously and are held for at least
// two aclk periods; osc_tick rises or pulses once per oscillator period
`timescale 1ns/10ps
`include "rcst_defines.svh"

module rcst_top #(
    parameter int unsigned PUP_CYCLES = `RCST_PUP_CYCLES,
    parameter int unsigned OSC_WAIT_PERIODS = `RCST_OSC_WAIT_PERIODS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic poweron_event,
    input wire logic brownout_event,
    input wire logic watchdog_reset_event,
    input wire logic watchdog_wake_event,
    input wire logic master_clear_pin_n,
    input wire logic sleeping,
    input wire logic supply_ok,
    input wire logic osc_tick,
    output logic device_hold,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: two flops, then a third for edge detection

    localparam int NSYNC = 8;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;

    assign pin_raw = {osc_tick, supply_ok, sleeping, ~master_clear_pin_n,
                      watchdog_wake_event, watchdog_reset_event,
                      brownout_event, poweron_event};

    always_ff @(posedge aclk) begin
        sync1 <= pin_raw;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    wire [NSYNC-1:0] rise = sync2 & ~sync3;
    wire ev_por = rise[0];
    wire ev_brown = rise[1];
    wire ev_wdog = rise[2];
    wire ev_wake = rise[3];
    wire ev_mreset = rise[4];
    wire in_sleep = sync2[5];
    wire vdd_ok = sync2[6];
    wire osc_edge = rise[7];

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite handshake

    logic aw_full;
    logic w_full;
    logic [7:0] aw_idx;
    logic aw_ok;
    logic [31:0] w_data;
    logic w_lane0;

    function automatic logic idx_ok(input logic [31:0] addr);
        logic [29:0] idx;
        idx = addr[31:2];
        idx_ok = (idx >= 30'(`RCST_IDX_CAUSE)) && (idx <= 30'(`RCST_IDX_CONFIG));
    endfunction

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire do_write = aw_full & w_full & ~s_axi_bvalid;
    wire next_aw_full = (aw_full & ~do_write) | aw_take;
    wire next_w_full = (w_full & ~do_write) | w_take;
    wire next_bvalid = (s_axi_bvalid & ~s_axi_bready) | do_write;
    wire next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;
    // byte lane 0 carries every implemented bit, so only wstrb[0] matters
    wire wr_en = do_write & aw_ok & w_lane0;
    wire wr_cause = wr_en & (aw_idx == `RCST_IDX_CAUSE);
    wire wr_core = wr_en & (aw_idx == `RCST_IDX_CORE);
    wire wr_en_reg = wr_en & (aw_idx == `RCST_IDX_IRQ_EN);
    wire wr_clr = wr_en & (aw_idx == `RCST_IDX_IRQ_CLR);
    wire wr_cfg = wr_en & (aw_idx == `RCST_IDX_CONFIG);
    wire [7:0] wbyte = w_data[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_idx <= 8'h00;
            aw_ok <= 1'b0;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= ~next_aw_full;
            s_axi_wready <= ~next_w_full;
            s_axi_bvalid <= next_bvalid;
            if (aw_take) begin
                aw_idx <= s_axi_awaddr[9:2];
                aw_ok <= idx_ok(s_axi_awaddr);
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bresp <= aw_ok ? 2'b00 : 2'b10;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset cause and core status flags

    logic [7:0] cause;
    logic [7:0] core;
    logic [7:0] config_reg;
    wire hw_power = ev_por | ev_brown;
    wire hw_any = hw_power | ev_wdog | ev_wake | ev_mreset;
    logic [7:0] next_cause;
    logic [7:0] next_core;

    always_comb begin
        next_cause = cause;
        next_core = core;
        if (wr_cause) begin
            next_cause = wbyte & `RCST_CAUSE_MASK; // RL5 RL16
        end
        if (wr_core) begin
            next_core = (core & ~`RCST_CORE_SW_MASK) | (wbyte & `RCST_CORE_SW_MASK);
        end
        // hardware events are applied last so they win over a same-cycle write
        if (hw_any) begin
            next_cause[`RCST_BIT_ULP_WAKE] = 1'b0; // RL10 RL16
            next_core[7:5] = 3'b000; // RL12
        end
        if (hw_power) begin
            next_cause[`RCST_BIT_SOFT_BROWN] = 1'b1; // RL10
            next_core[`RCST_BIT_TIMEOUT_N] = 1'b1; // RL8
            next_core[`RCST_BIT_PDOWN_N] = 1'b1; // RL8
        end
        if (ev_por) begin
            next_cause[`RCST_BIT_POR_N] = 1'b0; // RL4
        end
        // brown-out flag is left as is on power-on, where its value is undefined
        if (ev_brown) begin
            next_cause[`RCST_BIT_BROWN_N] = 1'b0; // RL2 RL3
        end
        if (ev_wdog) begin
            next_core[`RCST_BIT_TIMEOUT_N] = 1'b0; // RL9
        end
        if (ev_wake) begin
            next_core[`RCST_BIT_TIMEOUT_N] = 1'b0; // RL9
            next_core[`RCST_BIT_PDOWN_N] = 1'b0; // RL9
        end
        // master-clear while awake leaves the timeout and powerdown flags unchanged
        if (ev_mreset && in_sleep) begin
            next_core[`RCST_BIT_TIMEOUT_N] = 1'b1; // RL9
            next_core[`RCST_BIT_PDOWN_N] = 1'b0; // RL9
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause <= `RCST_CAUSE_POR;
            core <= `RCST_CORE_POR;
            config_reg <= `RCST_CONFIG_RESET;
        end else begin
            cause <= next_cause; // RL1 RL11
            core <= next_core;
            if (wr_cfg) begin
                config_reg <= wbyte & `RCST_CONFIG_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up timeout sequencer

    wire pup_en_n = config_reg[`RCST_BIT_PUP_EN_N];
    wire sec_osc = config_reg[`RCST_BIT_SECOSC];
    wire [1:0] osc_sel = config_reg[`RCST_BIT_OSC +: 2];

    // low-power crystal with the secondary input behaves like a non-crystal mode
    function automatic logic needs_osc_wait(input logic [1:0] sel, input logic sec);
        needs_osc_wait = (sel != 2'(rcst_pkg::OSC_NON_CRYSTAL))
                         && !((sel == 2'(rcst_pkg::OSC_LOW_POWER)) && sec);
    endfunction

    wire osc_wait = needs_osc_wait(osc_sel, sec_osc);
    rcst_pkg::rcst_state_t state;
    rcst_pkg::rcst_state_t next_state;
    logic [31:0] count;
    logic [31:0] next_count;
    logic done_pulse;

    // the supply wait precedes both timers so a sagging supply holds reset
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            rcst_pkg::ST_SUPPLY: begin
                next_count = 32'h0000_0000;
                if (vdd_ok) begin
                    if (!pup_en_n) begin
                        next_state = rcst_pkg::ST_PUP; // RL14 RL15
                    end else if (osc_wait) begin
                        next_state = rcst_pkg::ST_OSC; // RL6
                    end else begin
                        next_state = rcst_pkg::ST_RUN; // RL7
                    end
                end
            end
            rcst_pkg::ST_PUP: begin
                next_count = count + 32'h0000_0001;
                if (count >= PUP_CYCLES - 1) begin
                    next_count = 32'h0000_0000;
                    next_state = osc_wait ? rcst_pkg::ST_OSC : rcst_pkg::ST_RUN; // RL13 RL14
                end
            end
            rcst_pkg::ST_OSC: begin
                if (osc_edge) begin
                    next_count = count + 32'h0000_0001;
                    if (count >= OSC_WAIT_PERIODS - 1) begin
                        next_state = rcst_pkg::ST_RUN; // RL6
                    end
                end
            end
            rcst_pkg::ST_RUN: begin
                next_count = 32'h0000_0000;
            end
            default: begin
                next_state = rcst_pkg::ST_SUPPLY;
                next_count = 32'h0000_0000;
            end
        endcase
        // a brown-out at any time, including mid timer, restarts from the supply wait
        if (hw_power) begin
            next_state = rcst_pkg::ST_SUPPLY; // RL13
            next_count = 32'h0000_0000;
        end else if (ev_wake && state == rcst_pkg::ST_RUN && osc_wait) begin
            next_state = rcst_pkg::ST_OSC; // RL6 RL7
            next_count = 32'h0000_0000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= rcst_pkg::ST_SUPPLY;
            count <= 32'h0000_0000;
            device_hold <= 1'b1;
            done_pulse <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            device_hold <= (next_state != rcst_pkg::ST_RUN);
            done_pulse <= (next_state == rcst_pkg::ST_RUN) && (state != rcst_pkg::ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write-one-to-clear, enable mask

    localparam int NI = `RCST_IRQ_WIDTH;
    logic [NI-1:0] irq_stat;
    logic [NI-1:0] irq_en;
    wire [NI-1:0] irq_set = {done_pulse, ev_mreset, ev_wake, ev_wdog, ev_brown, ev_por};
    wire [NI-1:0] irq_clr = wr_clr ? wbyte[NI-1:0] : {NI{1'b0}};
    // set beats clear so an event in the clearing cycle is kept
    wire [NI-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= {NI{1'b0}};
            irq_en <= {NI{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_en_reg) begin
                irq_en <= wbyte[NI-1:0];
            end
            irq <= |(next_irq_stat & (wr_en_reg ? wbyte[NI-1:0] : irq_en));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [7:0] rd_byte;
    wire [7:0] ar_idx = s_axi_araddr[9:2];

    always_comb begin
        case (ar_idx)
            `RCST_IDX_CAUSE: rd_byte = cause;
            `RCST_IDX_CORE: rd_byte = core;
            `RCST_IDX_IRQ_STAT: rd_byte = 8'(irq_stat);
            `RCST_IDX_IRQ_EN: rd_byte = 8'(irq_en);
            `RCST_IDX_CONFIG: rd_byte = config_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= {24'h00_0000, idx_ok(s_axi_araddr) ? rd_byte : 8'h00};
                s_axi_rresp <= idx_ok(s_axi_araddr) ? 2'b00 : 2'b10;
            end
        end
    end

endmodule // rcst_top

// ---- verif/rcst_assertions.sv ----
// checker for rcst_top: bus handshakes and start-up hold
// assumes it is bound to rcst_top and sees its ports, one clock domain
`timescale 1ns/10ps
module rcst_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic brownout_event,
    input wire logic supply_ok,
    input wire logic device_hold
);
default clocking cb @(posedge aclk);
endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
a_write_block: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated after acceptance");
a_ready_release: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_arready)
    else $error("not ready after reset");
// a brown-out with the supply low must hold the core; timer restart hinges on it
a_hold_brownout: assert property ($rose(brownout_event) && !supply_ok |-> ##[1:8] device_hold)
    else $error("no hold after brown-out");
endmodule // rcst_assertions

// ---- verif/tb_top.sv ----
// self-checking bench for rcst_top: cause flags, interrupts, start-up hold
// assumes short timer parameters and osc_tick at one eighth of aclk
`timescale 1ns/10ps
`include "rcst_defines.svh"
module tb_top;
localparam int PW = 50;
localparam logic [7:0] CA = `RCST_IDX_CAUSE, CO = `RCST_IDX_CORE, ST = `RCST_IDX_IRQ_STAT;
localparam logic [7:0] EN = `RCST_IDX_IRQ_EN, CL = `RCST_IDX_IRQ_CLR, CF = `RCST_IDX_CONFIG;
logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
logic awready, wready, bvalid, arready, rvalid, device_hold, irq;
logic [1:0] bresp, rresp, rs;
logic [4:0] evs = '0;
logic sleeping = 0, supply_ok = 1;
logic [2:0] ocnt = '0;
int n_mismatch = 0, tests_run = 0;
always #10 aclk = ~aclk;
always @(posedge aclk) ocnt <= ocnt + 3'h1;
rcst_top #(.PUP_CYCLES(PW), .OSC_WAIT_PERIODS(4)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .poweron_event(evs[0]), .brownout_event(evs[1]), .watchdog_reset_event(evs[2]),
    .watchdog_wake_event(evs[3]), .master_clear_pin_n(!evs[4]), .sleeping(sleeping),
    .supply_ok(supply_ok), .osc_tick(ocnt[2]), .device_hold(device_hold), .irq(irq));
////////////////////////////////////////////////////////////////////////////////
task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
        n_mismatch++;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
endtask
task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a;
    logic w;
    a = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
        @(posedge aclk);
        if (!a && awready === 1'b1) begin
            a = 1;
            awvalid <= 1'b0;
        end
        if (!w && wready === 1'b1) begin
            w = 1;
            wvalid <= 1'b0;
        end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
endtask
task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    @(posedge aclk);
    araddr <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rs = rresp;
    rready <= 1'b0;
    check(nm, {24'h00_0000, exp}, rdata);
endtask
// event pins are held three cycles, then the flags get time to settle
task automatic ev(input int k);
    @(posedge aclk);
    evs[k] <= 1'b1;
    repeat (3) @(posedge aclk);
    evs[k] <= 1'b0;
    repeat (8) @(posedge aclk);
endtask
// counts cycles from the event to the end of the hold; rst2 repeats a brown-out mid-timer
task automatic su(input int k, input logic [7:0] cfg, input int lo, input int hi, input bit rst2);
    int n;
    wr(CF, cfg);
    n = 0;
    evs[k] <= 1'b1;
    while (n < 400 && !(n >= 12 && device_hold === 1'b0)) begin
        @(posedge aclk);
        n++;
        if (n == 3 || n == 33) evs[k] <= 1'b0;
        if (rst2 && n == 30) evs[k] <= 1'b1;
        if (rst2 && n == 30) supply_ok <= 1'b0;
        if (n == 40) supply_ok <= 1'b1;
    end
    check("hold_cycles", 32'h1, {31'h0, n >= lo && n <= hi});
endtask
task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rdc(CA, 8'h11, "cause");
    rdc(CO, 8'h18, "core");
    wr(CA, 8'hFF);
    rdc(CA, 8'h33, "cause");
    ev(1);
    rdc(CA, 8'h12, "cause");
    rdc(CO, 8'h18, "core");
    wr(CA, 8'h33);
    ev(0);
    rdc(CA, 8'h11, "cause");
    wr(CA, 8'h33);
    ev(2);
    rdc(CA, 8'h13, "cause");
    rdc(CO, 8'h08, "core");
    ev(3);
    rdc(CO, 8'h00, "core");
    ev(4);
    rdc(CO, 8'h00, "core");
    sleeping <= 1'b1;
    ev(4);
    rdc(CO, 8'h10, "core");
    sleeping <= 1'b0;
    wr(CO, 8'hFF);
    rdc(CO, 8'hF7, "core");
    ev(1);
    rdc(CO, 8'h1F, "core");
    // brown-out reaches the flags at the very edge the cause write lands
    evs[1] <= 1'b1;
    wr(CA, 8'h33);
    evs[1] <= 1'b0;
    repeat (8) @(posedge aclk);
    rdc(CA, 8'h12, "cause_race");
    rdc(8'h20, 8'h00, "unmapped");
    check("rresp", 32'h2, {30'h0, rs});
    wr(8'h20, 8'hFF);
    check("bresp", 32'h2, {30'h0, rs});
    $display("test flags done");
    repeat (150) @(posedge aclk);
    wr(CL, 8'h3F);
    wr(EN, 8'h00);
    ev(2);
    check("irq_masked", 32'h0, {31'h0, irq});
    rdc(ST, 8'h04, "irq_stat");
    wr(EN, 8'h04);
    repeat (2) @(posedge aclk);
    check("irq_on", 32'h1, {31'h0, irq});
    wr(CL, 8'h04);
    repeat (2) @(posedge aclk);
    check("irq_off", 32'h0, {31'h0, irq});
    rdc(ST, 8'h00, "irq_stat");
    $display("test irq done");
    su(1, 8'h06, 74, 100, 0);
    su(1, 8'h07, 26, 48, 0);
    su(1, 8'h1E, 50, 66, 0);
    su(1, 8'h1F, 12, 12, 0);
    su(3, 8'h1E, 12, 12, 0);
    su(3, 8'h06, 26, 48, 0);
    su(1, 8'h06, 105, 140, 1);
    $display("test startup done");
    final_report();
end
initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("watchdog expired");
    final_report();
end
endmodule // tb_top
bind rcst_top rcst_assertions chk (.*);
